// *** sld_pkg.sv ***
// Package for the supply level detector / 4-bit converter control block.
// Assumes a 40 MHz system clock and a plain nibble-wide register port.
package sld_pkg;

    // ==========================================
    // Register addresses (nibble registers)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_LEVEL = 4'h1;
    localparam logic [3:0] ADDR_TRIM = 4'h2;
    localparam logic [3:0] ADDR_IRQ2 = 4'h3;
    localparam logic [3:0] ADDR_MASK2 = 4'h4;
    localparam logic [3:0] ADDR_OPTCFG = 4'h5;
    localparam logic [3:0] ADDR_PINCFG = 4'h6;

    // ==========================================
    // Field positions
    localparam int CTRL_EXT_BIT = 3;
    localparam int CTRL_START_BIT = 2;
    localparam int CTRL_CONT_BIT = 1;
    localparam int CTRL_WDOG_BIT = 0;
    localparam int IRQ_LEVEL_BIT = 1;
    localparam int OPT_ALT15_BIT = 0;
    localparam int PIN_PULL_BIT = 0;

    // ==========================================
    // Level reset values and top level code
    localparam logic [1:0] LEVEL_RST_LOW = 2'h1;
    localparam logic [1:0] LEVEL_HI_OPT1 = 2'h2;
    localparam logic [1:0] LEVEL_HI_OPT0 = 2'h1;
    localparam logic [3:0] LEVEL_TOP_CODE = 4'hf;

    // ==========================================
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int SETTLE_TICKS = 2;
    localparam int MEAS_US = 260;
    localparam int MEAS_CYCLES = (MEAS_US * (CLK_HZ / 1_000_000) < 1) ? 1 : MEAS_US * (CLK_HZ / 1_000_000);

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARM = 4'b0010,
        ST_MEAS = 4'b0100,
        ST_CONT = 4'b1000
    } sld_state_t;

endpackage

// *** sld_ctrl.sv ***
// Control logic of the supply level detector that doubles as a 4-bit converter.
// Assumes prescaler taps and analog comparator output are synchronous to clk_in.
`timescale 1ns/1ps
module sld_ctrl #(
    parameter int MEAS_CYCLES = sld_pkg::MEAS_CYCLES,
    parameter logic [3:0] FACTORY_TRIM = 4'h8
) (
    input wire logic clk_in, // System clock
    input wire logic srst_in, // Power-on reset
    input wire logic ce_in, // Clock enable
    input wire logic [3:0] addr_in, // Register address
    input wire logic [3:0] wdata_in, // Write data
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    output logic [3:0] rdata_out, // Read data
    input wire logic sleep_in, // Device in sleep
    input wire logic powercheck_level_option_in, // Power-check level option
    input wire logic low_voltage_level_option_in, // Build option for level 15b
    input wire logic por_active_in, // Power-on reset phase active
    input wire logic prescaler_tap_fourteen_in, // Prescaler tap 14
    input wire logic prescaler_tap_fifteen_in, // Prescaler tap 15
    input wire logic comp_above_in, // Comparator: input above level
    output logic analog_enable_out, // Power reference, divider, comparator
    output logic ext_input_select_out, // 1: pin 4 input, 0: supply
    output logic [3:0] level_select_out, // Divider tap
    output logic level_alt15_out, // Use level 15b
    output logic [3:0] level_trim_out, // Trim code
    output logic pin4_block_out, // Block pin 4 digital functions
    output logic pin4_pull_disable_out, // Pull disable for pin 4
    output logic watchdog_disable_out, // Watchdog disable
    output logic level_irq_out // Level interrupt request flag
);

    // ==========================================
    // Registers
    sld_pkg::sld_state_t state_q;
    logic ext_q, cont_q, wdog_q, result_q, irq_q, mask_q, alt15_q, pull_q;
    logic [3:0] level_q, trim_q;
    logic t14_q, t15_q;
    logic [$clog2(MEAS_CYCLES+1)-1:0] cnt_q;
    logic [1:0] settle_q;

    wire t14_fall = t14_q & ~prescaler_tap_fourteen_in;
    wire t15_rise = ~t15_q & prescaler_tap_fifteen_in;
    wire wr_ctrl = wr_in & (addr_in == sld_pkg::ADDR_CTRL);
    wire start_wr = wr_ctrl & wdata_in[sld_pkg::CTRL_START_BIT];
    wire busy = (state_q == sld_pkg::ST_ARM) || (state_q == sld_pkg::ST_MEAS) || (cont_q && settle_q != 2'h0);
    wire meas_done = (state_q == sld_pkg::ST_MEAS) && (cnt_q == '0);
    wire cont_sample = (state_q == sld_pkg::ST_CONT) && settle_q == 2'h0 && t15_rise;
    // No sample in sleep: analog is being switched off and the comparator is unreliable
    wire sample = (meas_done | cont_sample) & ~sleep_in;
    wire irq_rd = rd_in & (addr_in == sld_pkg::ADDR_IRQ2);
    wire irq_wclr = wr_in & (addr_in == sld_pkg::ADDR_IRQ2) & wdata_in[sld_pkg::IRQ_LEVEL_BIT];

    // ==========================================
    // Tap edge detection
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            t14_q <= 1'b0;
            t15_q <= 1'b0;
        end
        else if (ce_in)
        begin
            t14_q <= prescaler_tap_fourteen_in;
            t15_q <= prescaler_tap_fifteen_in;
        end
    end

    // ==========================================
    // Control registers
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            ext_q <= 1'b0;
            cont_q <= 1'b0;
            wdog_q <= 1'b0;
            mask_q <= 1'b0;
            alt15_q <= 1'b0;
            pull_q <= 1'b0;
            trim_q <= FACTORY_TRIM;
        end
        else if (ce_in && wr_in)
        begin
            unique case (addr_in)
                sld_pkg::ADDR_CTRL:
                begin
                    ext_q <= wdata_in[sld_pkg::CTRL_EXT_BIT];
                    cont_q <= wdata_in[sld_pkg::CTRL_CONT_BIT];
                    wdog_q <= wdata_in[sld_pkg::CTRL_WDOG_BIT];
                end
                sld_pkg::ADDR_TRIM: trim_q <= wdata_in;
                sld_pkg::ADDR_MASK2: mask_q <= wdata_in[sld_pkg::IRQ_LEVEL_BIT];
                sld_pkg::ADDR_OPTCFG: alt15_q <= wdata_in[sld_pkg::OPT_ALT15_BIT];
                sld_pkg::ADDR_PINCFG: pull_q <= wdata_in[sld_pkg::PIN_PULL_BIT];
                default: ;
            endcase
        end
    end

    // ==========================================
    // Level select; reset value from the power-check option
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            level_q <= {2'h0, sld_pkg::LEVEL_RST_LOW}; // Option folded in while por_active_in is high
        else if (ce_in)
        begin
            if (por_active_in)
                level_q <= {powercheck_level_option_in ? sld_pkg::LEVEL_HI_OPT1
                            : sld_pkg::LEVEL_HI_OPT0, sld_pkg::LEVEL_RST_LOW};
            else if (wr_in && addr_in == sld_pkg::ADDR_LEVEL)
                level_q <= wdata_in;
        end
    end

    // ==========================================
    // Measurement sequencer
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            state_q <= sld_pkg::ST_IDLE;
            cnt_q <= '0;
        end
        else if (ce_in)
        begin
            if (sleep_in)
                state_q <= sld_pkg::ST_IDLE;
            else
            begin
                unique case (state_q)
                    sld_pkg::ST_IDLE:
                        if (cont_q)
                            state_q <= sld_pkg::ST_CONT;
                        else if (start_wr)
                            state_q <= sld_pkg::ST_ARM;
                    sld_pkg::ST_ARM:
                        if (t14_fall)
                        begin
                            state_q <= sld_pkg::ST_MEAS;
                            cnt_q <= ($clog2(MEAS_CYCLES+1))'(MEAS_CYCLES - 1);
                        end
                    sld_pkg::ST_MEAS:
                        if (cnt_q == '0)
                            state_q <= cont_q ? sld_pkg::ST_CONT : sld_pkg::ST_IDLE;
                        else
                            cnt_q <= cnt_q - 1'b1;
                    sld_pkg::ST_CONT:
                        if (!cont_q)
                            state_q <= sld_pkg::ST_IDLE;
                    default: state_q <= sld_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // ==========================================
    // Continuous mode settle, counted in tap-15 periods
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            settle_q <= 2'h0;
        else if (ce_in)
        begin
            if (!cont_q || sleep_in)
                settle_q <= 2'(sld_pkg::SETTLE_TICKS);
            else if (settle_q != 2'h0 && t15_rise)
                settle_q <= settle_q - 2'h1;
        end
    end

    // ==========================================
    // Result and interrupt flag
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            result_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (ce_in)
        begin
            if (sample)
                result_q <= comp_above_in;
            // Set wins over clear
            if (sample && !comp_above_in && mask_q)
                irq_q <= 1'b1;
            else if (irq_rd || irq_wclr)
                irq_q <= 1'b0;
        end
    end

    // ==========================================
    // Read data and outputs
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            rdata_out <= 4'h0;
        else if (ce_in)
        begin
            rdata_out <= 4'h0;
            if (rd_in)
            begin
                unique case (addr_in)
                    sld_pkg::ADDR_CTRL: rdata_out <= {result_q, busy, cont_q, wdog_q};
                    sld_pkg::ADDR_LEVEL: rdata_out <= level_q;
                    sld_pkg::ADDR_TRIM: rdata_out <= trim_q;
                    sld_pkg::ADDR_IRQ2: rdata_out <= {2'h0, irq_q, 1'b0};
                    sld_pkg::ADDR_MASK2: rdata_out <= {2'h0, mask_q, 1'b0};
                    sld_pkg::ADDR_OPTCFG: rdata_out <= {3'h0, alt15_q};
                    sld_pkg::ADDR_PINCFG: rdata_out <= {3'h0, pull_q};
                    default: rdata_out <= 4'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            analog_enable_out <= 1'b0;
            ext_input_select_out <= 1'b0;
            level_select_out <= 4'h0;
            level_alt15_out <= 1'b0;
            level_trim_out <= 4'h0;
            pin4_block_out <= 1'b0;
            pin4_pull_disable_out <= 1'b0;
            watchdog_disable_out <= 1'b0;
            level_irq_out <= 1'b0;
        end
        else if (ce_in)
        begin
            // Analog powered in a measurement, in continuous mode or in the power-on check; off in sleep
            analog_enable_out <= !sleep_in && (cont_q || state_q == sld_pkg::ST_MEAS
                                 || por_active_in);
            ext_input_select_out <= ext_q && !por_active_in;
            level_select_out <= level_q;
            level_alt15_out <= (level_q == sld_pkg::LEVEL_TOP_CODE)
                               && (alt15_q || low_voltage_level_option_in);
            level_trim_out <= trim_q;
            pin4_block_out <= ext_q;
            pin4_pull_disable_out <= pull_q;
            watchdog_disable_out <= wdog_q;
            level_irq_out <= irq_q;
        end
    end

endmodule

// *** sld_ctrl_checker.sv ***
// Checker on the level detector control ports.
// Assumes ce_in held high and one clock domain.
`timescale 1ns/1ps
module sld_ctrl_checker #(
    parameter logic [3:0] FACTORY_TRIM = 4'h8
) (
    input wire logic clk_in, // Clock
    input wire logic srst_in, // Reset
    input wire logic [3:0] addr_in, // Address
    input wire logic [3:0] wdata_in, // Data
    input wire logic wr_in, // Write
    input wire logic rd_in, // Read
    input wire logic [3:0] rdata_out, // Read data
    input wire logic sleep_in, // Sleep
    input wire logic powercheck_level_option_in, // Option
    input wire logic low_voltage_level_option_in, // Option
    input wire logic por_active_in, // Power check
    input wire logic comp_above_in, // Comparator
    input wire logic analog_enable_out, // Analog on
    input wire logic ext_input_select_out, // Pin input
    input wire logic [3:0] level_select_out, // Level
    input wire logic level_alt15_out, // Level 15b
    input wire logic [3:0] level_trim_out, // Trim
    input wire logic pin4_block_out, // Pin block
    input wire logic level_irq_out // Irq flag
);
    // ====
    // Properties
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    wire logic [1:0] por_hi = powercheck_level_option_in ? sld_pkg::LEVEL_HI_OPT1 : sld_pkg::LEVEL_HI_OPT0;
    a_sleep_off: assert property ((sleep_in && !por_active_in)[*3] |-> !analog_enable_out)
        else $error("analog on in sleep");
    a_ext_follow: assert property (wr_in && addr_in == sld_pkg::ADDR_CTRL && !por_active_in ##1 !por_active_in
        |-> ##1 ext_input_select_out == $past(wdata_in[sld_pkg::CTRL_EXT_BIT], 2)) else $error("input route wrong");
    a_level_follow: assert property (wr_in && addr_in == sld_pkg::ADDR_LEVEL
        |-> ##2 level_select_out == $past(wdata_in, 2)) else $error("level not applied");
    a_trim_reset: assert property ($fell(srst_in) |-> ##2 level_trim_out == FACTORY_TRIM)
        else $error("trim not reloaded");
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 4'h0)
        else $error("read data without read");
    a_irq_cause: assert property ($rose(level_irq_out) |-> $past(analog_enable_out, 2) && !$past(comp_above_in, 2))
        else $error("irq without low compare");
    a_pin_block: assert property (ext_input_select_out |-> pin4_block_out)
        else $error("pin not blocked");
    a_alt_level: assert property (level_select_out == sld_pkg::LEVEL_TOP_CODE && low_voltage_level_option_in
        |-> level_alt15_out) else $error("level 15b not chosen");
    a_por_check: assert property (por_active_in[*2] |-> ##1 analog_enable_out && !ext_input_select_out
        && level_select_out == {por_hi, sld_pkg::LEVEL_RST_LOW}) else $error("power check level wrong");
    cover property ($rose(level_irq_out));
    cover property (ext_input_select_out && analog_enable_out);
    cover property (rd_in && addr_in == sld_pkg::ADDR_IRQ2);
endmodule
bind sld_ctrl sld_ctrl_checker #(.FACTORY_TRIM(FACTORY_TRIM)) chk (.*);

// *** sld_analog_model.sv ***
// Comparator, band-gap and divider chain facing the control block.
// Assumes input and level are plain 4-bit level codes.
`timescale 1ns/1ps
module sld_analog_model (
    input wire logic clk_in, // Clock
    input wire logic analog_enable_in, // Powered
    input wire logic ext_input_select_in, // 1: pin 4
    input wire logic [3:0] level_select_in, // Level
    input wire logic [3:0] supply_level_in, // Supply code
    input wire logic [3:0] pin_level_in, // Pin code
    output logic comp_above_out // 1: above
);
    logic junk_q = 1'b0;
    logic [3:0] in_lvl;
    // Unpowered output wanders, so a stale sample cannot pass
    always @(posedge clk_in)
        junk_q <= ~junk_q;
    assign in_lvl = ext_input_select_in ? pin_level_in : supply_level_in;
    assign comp_above_out = analog_enable_in ? (in_lvl > level_select_in) : junk_q;
endmodule

// *** test_supply_level_detect_adc_ctrl.sv ***
// Self-checking bench for the supply level detector control block.
// Assumes the analog model stands in for comparator and divider.
`timescale 1ns/1ps
module test_supply_level_detect_adc_ctrl;
    typedef struct {string n; logic [3:0] v; logic [3:0] m;} sld_exp_t;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic por_active_in = 1'b1;
    logic sleep_in = 1'b0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic rd_seen = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [3:0] wdata_in = 4'h0;
    logic [3:0] sup_lvl = 4'hf;
    logic [3:0] pin_lvl = 4'h0;
    logic [7:0] tap_q = 8'h0;
    logic [3:0] rdata_out, level_select_out, level_trim_out, d, v, lv;
    logic analog_enable_out, ext_input_select_out, comp_above_in, level_alt15_out, pin4_block_out;
    logic pin4_pull_disable_out, watchdog_disable_out, level_irq_out, ext, msk, wclr, res;
    logic prev = 1'b0;
    logic [10:0] tbl [5] = '{{4'h3, 4'h9, 3'b010}, {4'hc, 4'h9, 3'b010}, {4'h2, 4'hc, 3'b110},
        {4'h2, 4'h4, 3'b000}, {4'h1, 4'hf, 3'b111}};
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    int seed = 38062;
    sld_exp_t exp_q [$];
    sld_exp_t e;
    // ====
    // Design, analog model, clock and prescaler taps
    sld_ctrl #(.MEAS_CYCLES(20)) uut (.*, .ce_in(1'b1), .powercheck_level_option_in(1'b1),
        .low_voltage_level_option_in(1'b1), .prescaler_tap_fourteen_in(tap_q[4]), .prescaler_tap_fifteen_in(tap_q[3]));
    sld_analog_model amod (.clk_in(clk_in), .analog_enable_in(analog_enable_out),
        .ext_input_select_in(ext_input_select_out), .level_select_in(level_select_out),
        .supply_level_in(sup_lvl), .pin_level_in(pin_lvl), .comp_above_out(comp_above_in));
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in)
        tap_q <= tap_q + 8'h1;
    // ====
    // Bus tasks and result watcher
    task automatic check(input string n, input logic [3:0] seen, input logic [3:0] expv);
        comparisons++;
        if (seen !== expv)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, expv, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [3:0] x);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= x;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // Mask zero marks a poll: the reply is kept in d, not compared
    task automatic rd(input logic [3:0] a, input logic [3:0] x, input logic [3:0] m, input string n);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        exp_q.push_back('{n, x, m});
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 100; i++)
        begin
            rd(sld_pkg::ADDR_CTRL, 4'h0, 4'h0, "");
            if (d[sld_pkg::CTRL_START_BIT] === 1'b0)
                return;
        end
        check("busy release", 4'h1, 4'h0);
    endtask
    task automatic test_done();
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        rd_seen <= rd_in;
        cyc <= cyc + 1;
        if (rd_seen && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            if (e.m !== 4'h0)
                check(e.n, rdata_out & e.m, e.v & e.m);
        end
        if (cyc == 5000)
        begin
            error_cnt++;
            test_done();
        end
    end
    // ====
    // Scenarios
    initial
    begin
        repeat (10) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        por_active_in <= 1'b0;
        rd(sld_pkg::ADDR_LEVEL, 4'h9, 4'hf, "level reset");
        rd(sld_pkg::ADDR_TRIM, 4'h8, 4'hf, "trim reset");
        wr(4'h9, 4'h5);
        rd(4'h9, 4'h0, 4'hf, "unmapped");
        wr(sld_pkg::ADDR_TRIM, 4'h3);
        rd(sld_pkg::ADDR_TRIM, 4'h3, 4'hf, "trim");
        wr(sld_pkg::ADDR_PINCFG, 4'h1);
        rd(sld_pkg::ADDR_PINCFG, 4'h1, 4'hf, "pull disable reg");
        check("pull disable pin", {3'h0, pin4_pull_disable_out}, 4'h1);
        wr(sld_pkg::ADDR_CTRL, 4'h1);
        rd(sld_pkg::ADDR_CTRL, 4'h1, 4'h3, "watchdog reg");
        check("watchdog pin", {3'h0, watchdog_disable_out}, 4'h1);
        wr(sld_pkg::ADDR_LEVEL, 4'hf);
        wr(sld_pkg::ADDR_OPTCFG, 4'h1);
        rd(sld_pkg::ADDR_OPTCFG, 4'h1, 4'hf, "alt option reg");
        check("alt level pin", {3'h0, level_alt15_out}, 4'h1);
        repeat (4)
        begin
            v = 4'($random(seed));
            wr(sld_pkg::ADDR_LEVEL, v);
            rd(sld_pkg::ADDR_LEVEL, v, 4'hf, "level");
        end
        foreach (tbl[i])
        begin
            {lv, v, ext, msk, wclr} = tbl[i];
            sup_lvl <= ext ? 4'hf : lv;
            pin_lvl <= ext ? lv : 4'h0;
            res = lv > v;
            wr(sld_pkg::ADDR_LEVEL, v);
            wr(sld_pkg::ADDR_MASK2, {2'b00, msk, 1'b0});
            wr(sld_pkg::ADDR_CTRL, {ext, 3'b100});
            rd(sld_pkg::ADDR_CTRL, {prev, 3'b100}, 4'hc, "busy and old result");
            wait_idle();
            rd(sld_pkg::ADDR_CTRL, {res, 3'b000}, 4'h8, "result");
            if (wclr)
                wr(sld_pkg::ADDR_IRQ2, 4'h2);
            rd(sld_pkg::ADDR_IRQ2, {2'b00, !res && msk && !wclr, 1'b0}, 4'h2, "irq");
            rd(sld_pkg::ADDR_IRQ2, 4'h0, 4'h2, "irq after read");
            prev = res;
        end
        sup_lvl <= 4'h3;
        wr(sld_pkg::ADDR_LEVEL, 4'h6);
        wr(sld_pkg::ADDR_MASK2, 4'h2);
        wr(sld_pkg::ADDR_CTRL, 4'h2);
        rd(sld_pkg::ADDR_CTRL, 4'h6, 4'h6, "settle busy");
        wait_idle();
        repeat (40) @(posedge clk_in);
        rd(sld_pkg::ADDR_IRQ2, 4'h2, 4'h2, "continuous irq");
        rd(sld_pkg::ADDR_CTRL, 4'h0, 4'h8, "continuous below");
        wr(sld_pkg::ADDR_LEVEL, 4'h1);
        repeat (24) @(posedge clk_in);
        rd(sld_pkg::ADDR_CTRL, 4'h8, 4'h8, "continuous above");
        wr(sld_pkg::ADDR_MASK2, 4'h0);
        // Successive approximation on pin 4; keeps a bit when input is above the trial
        v = 4'($random(seed));
        pin_lvl <= v;
        wr(sld_pkg::ADDR_CTRL, 4'ha);
        wait_idle();
        lv = 4'h0;
        for (int b = 3; b >= 0; b--)
        begin
            lv[b] = 1'b1;
            wr(sld_pkg::ADDR_LEVEL, lv);
            repeat (24) @(posedge clk_in);
            rd(sld_pkg::ADDR_CTRL, 4'h0, 4'h0, "");
            if (d[sld_pkg::CTRL_EXT_BIT] !== 1'b1)
                lv[b] = 1'b0;
        end
        check("conversion", lv, (v == 4'h0) ? 4'h0 : v - 4'h1);
        wr(sld_pkg::ADDR_CTRL, 4'h0);
        sleep_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        sleep_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        test_done();
    end
endmodule
